//--- ptc_pkg.sv
// shared constants and types for the timer and counter unit
package ptc_pkg;
  // sizes
  localparam int NSLOT = 8;
  localparam int AW = 13;
  localparam int MEM_WORDS = 4096;
  // bus map: data memory below, slot registers above
  localparam logic [4:0] CTL_PAGE = 5'h10;
  localparam logic [AW-1:0] REG_DONE = 13'h1100;
  localparam logic [AW-1:0] REG_ERR = 13'h1101;
  localparam logic [1:0] OFS_CTL = 2'h0;
  localparam logic [1:0] OFS_PLO = 2'h1;
  localparam logic [1:0] OFS_PHI = 2'h2;
  localparam int CTL_CMD_BIT = 15;
  // counter values sit 1000 octal above the counter number
  localparam logic [11:0] CTR_BASE = 12'h200;
  // legal preset words: 1200-7377 and 7400-7577 octal
  localparam logic [11:0] PRE_LO1 = 12'h280;
  localparam logic [11:0] PRE_HI1 = 12'heff;
  localparam logic [11:0] PRE_LO2 = 12'hf00;
  localparam logic [11:0] PRE_HI2 = 12'hf7f;
  // saturation limits in bcd
  localparam logic [31:0] MAX4 = 32'h0000_9999;
  localparam logic [31:0] MAX7 = 32'h0999_9999;
  localparam logic [31:0] MAX8 = 32'h9999_9999;
  // time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 10000000;
  localparam logic [3:0] TENTH_DIV = 4'ha;
  // reset values
  localparam logic [15:0] PRESET_RST = 16'h0000;
  // kinds of slot
  typedef enum logic [2:0] {
    KIND_OFF, KIND_TIMER, KIND_TIMER_FAST, KIND_ACC, KIND_ACC_FAST,
    KIND_UP, KIND_STAGE, KIND_UPDN
  } ptc_kind_type;
  // slot control word
  typedef struct packed {
    logic [6:0] number;
    logic in_c;
    logic in_b;
    logic in_a;
    logic from_mem;
    ptc_kind_type kind;
  } ptc_cfg_type;
  localparam ptc_cfg_type CFG_RST = '{number: 7'h00, in_c: 1'b0, in_b: 1'b0,
    in_a: 1'b0, from_mem: 1'b0, kind: KIND_OFF};
endpackage : ptc_pkg

//--- ptc_timer_counter_unit.sv
// timer and counter unit with its own data memory and slot registers
//
// Summary of operation
// - tenth and hundredth second single-input timers
// - single timer runs on input, zero when off
// - timer value lives in word equal number
// - timer done when value at least preset
// - preset is constant or word in legal range
// - input off clears done and value
// - tenth second two-input accumulating timer
// - hundredth second accumulating timer, 99999.99 max
// - enable off holds count, resumes later
// - reset input zeroes count and done
// - eight digits in two consecutive words
// - up counter steps on each rising input
// - counter reset holds value at zero
// - counter saturates at 9999 until reset
// - counter value in word number plus 1000
// - counter done when value at least preset
// - up/down counter with three inputs, eight digits
// - stage counter cleared only by reset command
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module ptc_timer_counter_unit
  import ptc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // status
  output logic [NSLOT-1:0] done,
  output logic [NSLOT-1:0] preset_err
);

  // engine states
  typedef enum logic [3:0] {
    ST_CLEAR, ST_CUR_LO, ST_CUR_HI, ST_PRE_LO, ST_PRE_HI, ST_CALC,
    ST_WR_LO, ST_WR_HI
  } ptc_state_type;

  logic [15:0] mem [MEM_WORDS]; // data memory
  ptc_cfg_type cfg_ff [NSLOT]; // slot control words
  logic [15:0] plo_ff [NSLOT]; // preset low word or address
  logic [15:0] phi_ff [NSLOT]; // preset high digits
  logic pend_h_ff [NSLOT]; // hundredth tick seen
  logic pend_t_ff [NSLOT]; // tenth tick seen
  logic cmd_rst_ff [NSLOT]; // stage reset command waiting
  logic prev_a_ff [NSLOT]; // input a at last evaluation
  logic prev_c_ff [NSLOT]; // input c at last evaluation
  logic [NSLOT-1:0] done_ff; // done bits
  logic [NSLOT-1:0] err_ff; // bad preset address
  logic [15:0] rdata_ff; // read data
  logic [31:0] tick_ctr_ff; // hundredth divider
  logic [3:0] tenth_ctr_ff; // tenth divider
  ptc_state_type state_ff; // engine state
  logic [2:0] slot_ff; // slot in evaluation
  logic [11:0] clr_ff; // memory clear pointer
  logic [31:0] cur_ff; // current value being worked
  logic [31:0] pre_ff; // preset being worked
  logic [31:0] nxt_cur; // updated value
  logic nxt_done; // updated done
  logic nxt_err; // preset address check
  logic hund_tick; // one-cycle 10 ms tick
  logic tenth_tick; // one-cycle 100 ms tick
  logic bus_mem_wr; // bus writes memory
  logic slot_hit; // bus hits slot registers
  logic [2:0] bus_slot; // slot under bus
  logic eval_clr; // slot evaluated this cycle
  ptc_cfg_type cfg; // config of slot in work
  logic wide; // eight-digit kind
  logic is_ctr; // counter kind
  logic [11:0] cur_addr; // low word of current value
  logic [11:0] eng_addr; // engine memory address
  logic [15:0] mem_q; // engine read data
  logic eng_we; // engine writes memory
  logic [15:0] eng_wd; // engine write data

  // decimal increment with saturation
  function automatic logic [31:0] bcd_inc(input logic [31:0] v, input logic [31:0] lim);
    logic [31:0] r;
    logic carry;
    r = v;
    carry = 1'b1;
    if (v >= lim) begin
      r = lim;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (carry) begin
          if (r[i*4 +: 4] == 4'h9) begin
            r[i*4 +: 4] = 4'h0;
          end else begin
            r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
            carry = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : bcd_inc

  // decimal decrement, stops at zero
  function automatic logic [31:0] bcd_dec(input logic [31:0] v);
    logic [31:0] r;
    logic borrow;
    r = v;
    borrow = (v != 32'h0);
    for (int i = 0; i < 8; i++) begin
      if (borrow) begin
        if (r[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_dec

  // address decode
  assign bus_mem_wr = wr && !addr[12];
  assign bus_slot = addr[4:2];
  assign slot_hit = (addr[12:8] == CTL_PAGE) && (addr[7:5] == 3'h0) && (addr[1:0] != 2'h3);

  // time base: 10 ms tick and every tenth of them
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_ctr_ff <= 32'h0;
    end else if (hund_tick) begin
      tick_ctr_ff <= 32'h0;
    end else begin
      tick_ctr_ff <= tick_ctr_ff + 32'h1;
    end
  end
  assign hund_tick = (tick_ctr_ff == 32'(TICK_CYCLES - 1));

  // tenth divider
  always_ff @(posedge clk) begin
    if (rst) begin
      tenth_ctr_ff <= 4'h0;
    end else if (tenth_tick) begin
      tenth_ctr_ff <= 4'h0;
    end else if (hund_tick) begin
      tenth_ctr_ff <= tenth_ctr_ff + 4'h1;
    end
  end
  assign tenth_tick = hund_tick && (tenth_ctr_ff == TENTH_DIV - 4'h1);

  assign eval_clr = (state_ff == ST_CALC);

  // per-slot registers and event flags
  for (genvar gi = 0; gi < NSLOT; gi++) begin : g_slot
    // control and preset words
    always_ff @(posedge clk) begin
      if (rst) begin
        cfg_ff[gi] <= CFG_RST;
        plo_ff[gi] <= PRESET_RST;
        phi_ff[gi] <= PRESET_RST;
      end else if (wr && slot_hit && bus_slot == 3'(gi)) begin
        if (addr[1:0] == OFS_CTL) begin
          cfg_ff[gi] <= ptc_cfg_type'(wdata[13:0]);
        end else if (addr[1:0] == OFS_PLO) begin
          plo_ff[gi] <= wdata;
        end else begin
          phi_ff[gi] <= wdata;
        end
      end
    end
    // tick flags: a tick in the clearing cycle is kept
    always_ff @(posedge clk) begin
      if (rst) begin
        pend_h_ff[gi] <= 1'b0;
        pend_t_ff[gi] <= 1'b0;
      end else begin
        if (hund_tick) begin
          pend_h_ff[gi] <= 1'b1;
        end else if (eval_clr && slot_ff == 3'(gi)) begin
          pend_h_ff[gi] <= 1'b0;
        end
        if (tenth_tick) begin
          pend_t_ff[gi] <= 1'b1;
        end else if (eval_clr && slot_ff == 3'(gi)) begin
          pend_t_ff[gi] <= 1'b0;
        end
      end
    end
    // reset command, only clearing path for the stage counter
    always_ff @(posedge clk) begin
      if (rst) begin
        cmd_rst_ff[gi] <= 1'b0;
      end else if (wr && slot_hit && bus_slot == 3'(gi) && addr[1:0] == OFS_CTL &&
                   wdata[CTL_CMD_BIT]) begin
        cmd_rst_ff[gi] <= 1'b1;
      end else if (eval_clr && slot_ff == 3'(gi)) begin
        cmd_rst_ff[gi] <= 1'b0;
      end
    end
  end

  // slot in work and its value placement
  assign cfg = cfg_ff[slot_ff];
  assign wide = (cfg.kind == KIND_ACC) || (cfg.kind == KIND_ACC_FAST) ||
                (cfg.kind == KIND_UPDN);
  assign is_ctr = (cfg.kind == KIND_UP) || (cfg.kind == KIND_STAGE) ||
                  (cfg.kind == KIND_UPDN);
  assign cur_addr = is_ctr ? CTR_BASE + {5'h0, cfg.number} : {5'h0, cfg.number};

  // engine memory address by state
  always_comb begin
    case (state_ff)
      ST_CLEAR: eng_addr = clr_ff;
      ST_CUR_HI, ST_WR_HI: eng_addr = cur_addr + 12'h1;
      ST_PRE_LO: eng_addr = plo_ff[slot_ff][11:0];
      ST_PRE_HI: eng_addr = plo_ff[slot_ff][11:0] + 12'h1;
      default: eng_addr = cur_addr;
    endcase
  end
  assign mem_q = mem[eng_addr];
  // bus writes win; the engine simply waits a cycle
  assign eng_we = !bus_mem_wr && ((state_ff == ST_CLEAR) || (state_ff == ST_WR_LO) ||
                                  (state_ff == ST_WR_HI));
  assign eng_wd = (state_ff == ST_CLEAR) ? 16'h0 :
                  (state_ff == ST_WR_HI) ? cur_ff[31:16] : cur_ff[15:0];

  // data memory write port
  always_ff @(posedge clk) begin
    if (bus_mem_wr) begin
      mem[addr[11:0]] <= wdata;
    end else if (eng_we) begin
      mem[eng_addr] <= eng_wd;
    end
  end

  // next value and done of the slot in work
  always_comb begin
    logic tick;
    logic rise_a;
    logic rise_c;
    logic held;
    tick = 1'b0;
    rise_a = cfg.in_a && !prev_a_ff[slot_ff];
    rise_c = cfg.in_c && !prev_c_ff[slot_ff];
    held = 1'b0;
    nxt_cur = cur_ff;
    case (cfg.kind)
      KIND_TIMER_FAST, KIND_ACC_FAST: tick = pend_h_ff[slot_ff];
      default: tick = pend_t_ff[slot_ff];
    endcase
    case (cfg.kind)
      KIND_TIMER, KIND_TIMER_FAST: begin
        if (!cfg.in_a) begin
          nxt_cur = 32'h0;
          held = 1'b1;
        end else if (tick) begin
          nxt_cur = bcd_inc(cur_ff, MAX4);
        end
      end
      KIND_ACC, KIND_ACC_FAST: begin
        if (cfg.in_b) begin
          nxt_cur = 32'h0;
          held = 1'b1;
        end else if (cfg.in_a && tick) begin
          // enable off leaves the count alone
          nxt_cur = bcd_inc(cur_ff, (cfg.kind == KIND_ACC) ? MAX8 : MAX7);
        end
      end
      KIND_UP: begin
        if (cfg.in_b) begin
          nxt_cur = 32'h0;
          held = 1'b1;
        end else if (rise_a) begin
          nxt_cur = bcd_inc(cur_ff, MAX4);
        end
      end
      KIND_STAGE: begin
        if (cmd_rst_ff[slot_ff]) begin
          nxt_cur = 32'h0;
          held = 1'b1;
        end else if (rise_a) begin
          nxt_cur = bcd_inc(cur_ff, MAX4);
        end
      end
      KIND_UPDN: begin
        // a count edge only acts while the other count input is off
        if (cfg.in_b) begin
          nxt_cur = 32'h0;
          held = 1'b1;
        end else if (rise_a && !cfg.in_c) begin
          nxt_cur = bcd_inc(cur_ff, MAX8);
        end else if (rise_c && !cfg.in_a) begin
          nxt_cur = bcd_dec(cur_ff);
        end
      end
      default: nxt_cur = cur_ff;
    endcase
    // presets from memory must come from the legal windows
    nxt_err = cfg.from_mem &&
              !((plo_ff[slot_ff][11:0] >= PRE_LO1 && plo_ff[slot_ff][11:0] <= PRE_HI1) ||
                (plo_ff[slot_ff][11:0] >= PRE_LO2 && plo_ff[slot_ff][11:0] <= PRE_HI2));
    // packed bcd orders like binary, so a plain compare works
    nxt_done = !held && !nxt_err && (nxt_cur >= pre_ff);
  end

  // evaluation engine: sweeps the slots forever
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_CLEAR;
      clr_ff <= 12'h0;
      slot_ff <= 3'h0;
      cur_ff <= 32'h0;
      pre_ff <= 32'h0;
    end else begin
      case (state_ff)
        ST_CLEAR: begin
          // memory starts at zero so no value is unknown
          if (eng_we) begin
            clr_ff <= clr_ff + 12'h1;
            if (clr_ff == 12'hfff) begin
              state_ff <= ST_CUR_LO;
            end
          end
        end
        ST_CUR_LO: begin
          cur_ff <= {16'h0, mem_q};
          if (cfg.kind == KIND_OFF) begin
            slot_ff <= slot_ff + 3'h1; // idle slot skipped
          end else if (wide) begin
            state_ff <= ST_CUR_HI;
          end else begin
            state_ff <= ST_PRE_LO;
          end
        end
        ST_CUR_HI: begin
          cur_ff[31:16] <= mem_q;
          state_ff <= ST_PRE_LO;
        end
        ST_PRE_LO: begin
          if (cfg.from_mem) begin
            pre_ff <= {16'h0, mem_q};
            state_ff <= wide ? ST_PRE_HI : ST_CALC;
          end else begin
            pre_ff <= {wide ? phi_ff[slot_ff] : 16'h0, plo_ff[slot_ff]};
            state_ff <= ST_CALC;
          end
        end
        ST_PRE_HI: begin
          pre_ff[31:16] <= mem_q;
          state_ff <= ST_CALC;
        end
        ST_CALC: begin
          cur_ff <= nxt_cur;
          state_ff <= ST_WR_LO;
        end
        ST_WR_LO: begin
          if (eng_we) begin
            if (wide) begin
              state_ff <= ST_WR_HI;
            end else begin
              state_ff <= ST_CUR_LO;
              slot_ff <= slot_ff + 3'h1;
            end
          end
        end
        ST_WR_HI: begin
          if (eng_we) begin
            state_ff <= ST_CUR_LO;
            slot_ff <= slot_ff + 3'h1;
          end
        end
        default: state_ff <= ST_CLEAR;
      endcase
    end
  end

  // done, error and edge history, taken at evaluation
  always_ff @(posedge clk) begin
    if (rst) begin
      done_ff <= '0;
      err_ff <= '0;
      for (int i = 0; i < NSLOT; i++) begin
        prev_a_ff[i] <= 1'b0;
        prev_c_ff[i] <= 1'b0;
      end
    end else if (eval_clr) begin
      done_ff[slot_ff] <= nxt_done;
      err_ff[slot_ff] <= nxt_err;
      prev_a_ff[slot_ff] <= cfg.in_a;
      prev_c_ff[slot_ff] <= cfg.in_c;
    end
  end

  // read port: data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata_ff <= 16'h0;
    end else if (!addr[12]) begin
      rdata_ff <= mem[addr[11:0]];
    end else if (slot_hit && addr[1:0] == OFS_CTL) begin
      rdata_ff <= {2'h0, cfg_ff[bus_slot]};
    end else if (slot_hit && addr[1:0] == OFS_PLO) begin
      rdata_ff <= plo_ff[bus_slot];
    end else if (slot_hit) begin
      rdata_ff <= phi_ff[bus_slot];
    end else if (addr == REG_DONE) begin
      rdata_ff <= {{(16 - NSLOT){1'b0}}, done_ff};
    end else if (addr == REG_ERR) begin
      rdata_ff <= {{(16 - NSLOT){1'b0}}, err_ff};
    end else begin
      rdata_ff <= 16'h0; // unmapped
    end
  end

  assign rdata = rdata_ff;
  assign done = done_ff;
  assign preset_err = err_ff;

endmodule : ptc_timer_counter_unit

//--- ptc_tcu_chk.sv
// port assertions for the timer and counter unit
`timescale 1ns/1ps
module ptc_tcu_chk
  import ptc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // status
  input wire logic [NSLOT-1:0] done,
  input wire logic [NSLOT-1:0] preset_err
);
  // slot 0 control word as it should read back; bit 15 is never stored
  logic [13:0] ctl0_ff;
  // track writes to slot 0 control
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl0_ff <= 14'h0000;
    end else if (wr && addr == 13'h1000) begin
      ctl0_ff <= wdata[13:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside an answer");
  chk_unmapped_zero: assert property (rd && addr[12] && addr[1:0] == 2'h3 |=> rdata == 16'h0000)
    else $error("unmapped slot word did not read zero");
  chk_done_read: assert property (rd && addr == REG_DONE |=> rdata == {8'h00, $past(done)})
    else $error("done register disagrees with done port");
  chk_err_read: assert property (rd && addr == REG_ERR |=> rdata == {8'h00, $past(preset_err)})
    else $error("error register disagrees with error port");
  chk_ctl_readback: assert property (rd && addr == 13'h1000 |=> rdata == {2'b00, ctl0_ff})
    else $error("slot control read back wrong");
  chk_reset_clear: assert property ($fell(rst) |-> done == '0 && preset_err == '0)
    else $error("status not clear after reset");
  chk_err_blocks_done: assert property ((preset_err & done) == '0)
    else $error("done set on a slot with a bad preset");
  chk_one_slot_step: assert property ($countones(done ^ $past(done)) <= 1)
    else $error("more than one done bit moved in a cycle");
endmodule : ptc_tcu_chk

//--- ptc_ladder_model.sv
// bus master model standing in for the ladder program
`timescale 1ns/1ps
module ptc_ladder_model
  import ptc_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic [AW-1:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata
);
  // bus idle from time zero
  initial begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one write, strobe dropped at the taking edge
  task automatic bus_write(input logic [AW-1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_write
  // one read; data stand only in the cycle after the strobe
  task automatic bus_read(input logic [AW-1:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_read
  // presets go first so a slot never arms on a stale preset
  task automatic set_slot(input logic [2:0] s, input logic [15:0] ctl,
    input logic [15:0] plo, input logic [15:0] phi);
    bus_write({CTL_PAGE, 3'b000, s, OFS_PLO}, plo);
    bus_write({CTL_PAGE, 3'b000, s, OFS_PHI}, phi);
    bus_write({CTL_PAGE, 3'b000, s, OFS_CTL}, ctl);
  endtask : set_slot
endmodule : ptc_ladder_model

//--- tb_top.sv
// self-checking bench for the timer and counter unit
`timescale 1ns/1ps
module tb_top
  import ptc_pkg::*;
;
  localparam int TICKS = 20; // short tick keeps the run small
  logic clk;
  logic rst;
  logic [AW-1:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [NSLOT-1:0] done;
  logic [NSLOT-1:0] preset_err;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0; // hang guard
  logic [15:0] v;
  logic [15:0] held;
  ptc_timer_counter_unit #(.TICK_CYCLES(TICKS)) i_ptc_timer_counter_unit (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .done(done), .preset_err(preset_err)
  );
  ptc_ladder_model i_ptc_ladder_model (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
  );
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // whole run is near 10000 cycles, so this only trips on a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  task automatic cmp_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_word
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp_bit
  task automatic chk_read(input string name, input logic [AW-1:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_ptc_ladder_model.bus_read(a, d);
    cmp_word(name, exp, d);
  endtask : chk_read
  task automatic put(input logic [AW-1:0] a, input logic [15:0] d);
    i_ptc_ladder_model.bus_write(a, d);
  endtask : put
  // wait, then step past the edge so registered outputs have landed
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  // count pulses on slot 1; each level outlasts a full sweep
  task automatic pulses(input int n, input logic [15:0] base);
    pulse_at(13'h1004, base, 16'h0010, n);
  endtask : pulses
  // pulses on any slot control word and any input bit
  task automatic pulse_at(input logic [AW-1:0] a, input logic [15:0] base,
    input logic [15:0] m, input int n);
    repeat (n) begin
      put(a, base | m);
      idle(100);
      put(a, base);
      idle(100);
    end
  endtask : pulse_at
  function automatic logic bcd_ok(input logic [15:0] x);
    return x[3:0] < 4'ha && x[7:4] < 4'ha && x[11:8] < 4'ha && x[15:12] < 4'ha;
  endfunction : bcd_ok
  // main sequence
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    idle(4100); // memory writes only after the zero fill
    // fast single timer: slot 0, number 3, preset 2
    i_ptc_ladder_model.set_slot(3'd0, 16'h0192, 16'h0002, 16'h0000);
    idle(5);
    cmp_bit("timer done early", 1'b0, done[0]);
    idle(300);
    cmp_bit("timer done", 1'b1, done[0]);
    i_ptc_ladder_model.bus_read(13'h0003, v);
    cmp_bit("timer word", 1'b1, bcd_ok(v) && v >= 16'h0002);
    chk_read("timer ctl", 13'h1000, 16'h0192);
    put(13'h1000, 16'h0182);
    idle(100);
    cmp_bit("timer done off", 1'b0, done[0]);
    chk_read("timer word off", 13'h0003, 16'h0000);
    // up counter: slot 1, number 2, preset 3, value in word 0x202
    i_ptc_ladder_model.set_slot(3'd1, 16'h0105, 16'h0003, 16'h0000);
    pulses(2, 16'h0105);
    cmp_bit("count done at two", 1'b0, done[1]);
    pulses(1, 16'h0105);
    cmp_bit("count done at three", 1'b1, done[1]);
    chk_read("count word", 13'h0202, 16'h0003);
    chk_read("done reg", REG_DONE, 16'h0002);
    chk_read("unmapped slot word", 13'h1007, 16'h0000);
    pulses(1, 16'h0125);
    chk_read("count reset word", 13'h0202, 16'h0000);
    cmp_bit("count reset done", 1'b0, done[1]);
    // slot off first so the engine cannot overwrite the seeded word
    put(13'h1004, 16'h0100);
    idle(20);
    put(13'h0202, 16'h0009);
    put(13'h1004, 16'h0105);
    pulses(1, 16'h0105);
    chk_read("count digit carry", 13'h0202, 16'h0010);
    put(13'h1004, 16'h0100);
    idle(20);
    put(13'h0202, 16'h9998);
    put(13'h1004, 16'h0105);
    pulses(3, 16'h0105);
    chk_read("count saturate", 13'h0202, 16'h9999);
    // memory preset just below, then at, the legal window
    i_ptc_ladder_model.set_slot(3'd2, 16'h000d, 16'h027f, 16'h0000);
    idle(100);
    cmp_bit("preset err low", 1'b1, preset_err[2]);
    chk_read("err reg", REG_ERR, 16'h0004);
    put(13'h1009, 16'h0280);
    idle(100);
    cmp_bit("preset err edge", 1'b0, preset_err[2]);
    cmp_bit("zero preset done", 1'b1, done[2]);
    // accumulating fast timer: slot 3, number 4, words 4 and 5
    i_ptc_ladder_model.set_slot(3'd3, 16'h0214, 16'h0005, 16'h0000);
    idle(600);
    put(13'h100c, 16'h0204);
    idle(100);
    i_ptc_ladder_model.bus_read(13'h0004, held);
    cmp_bit("acc done", 1'b1, done[3]);
    cmp_bit("acc bcd", 1'b1, bcd_ok(held));
    idle(300);
    chk_read("acc held", 13'h0004, held);
    chk_read("acc high word", 13'h0005, 16'h0000);
    put(13'h100c, 16'h0214);
    idle(200);
    i_ptc_ladder_model.bus_read(13'h0004, v);
    cmp_bit("acc resumes", 1'b1, v > held);
    put(13'h100c, 16'h0234);
    idle(100);
    chk_read("acc reset word", 13'h0004, 16'h0000);
    cmp_bit("acc reset done", 1'b0, done[3]);
    // stage counter: slot 4, number 5, word 0x205, preset 2
    i_ptc_ladder_model.set_slot(3'd4, 16'h0286, 16'h0002, 16'h0000);
    pulse_at(13'h1010, 16'h0286, 16'h0010, 2);
    cmp_bit("stage done", 1'b1, done[4]);
    // the reset input must not clear a stage counter
    put(13'h1010, 16'h02a6);
    idle(100);
    chk_read("stage keeps value", 13'h0205, 16'h0002);
    put(13'h1010, 16'h8286);
    idle(100);
    chk_read("stage cmd word", 13'h0205, 16'h0000);
    cmp_bit("stage cmd done", 1'b0, done[4]);
    chk_read("stage ctl no cmd bit", 13'h1010, 16'h0286);
    // up/down counter: slot 5, number 6, words 0x206 and 0x207, preset 2
    i_ptc_ladder_model.set_slot(3'd5, 16'h0307, 16'h0002, 16'h0000);
    pulse_at(13'h1014, 16'h0307, 16'h0010, 3);
    cmp_bit("updn done at three", 1'b1, done[5]);
    pulse_at(13'h1014, 16'h0307, 16'h0040, 2);
    chk_read("updn down word", 13'h0206, 16'h0001);
    chk_read("updn high word", 13'h0207, 16'h0000);
    cmp_bit("updn done at one", 1'b0, done[5]);
    // tenth accumulating timer: slot 6, number 8, seeded 9999, preset 10000
    put(13'h0008, 16'h9999);
    i_ptc_ladder_model.set_slot(3'd6, 16'h0413, 16'h0000, 16'h0001);
    idle(100);
    chk_read("acc carry high", 13'h0009, 16'h0001);
    i_ptc_ladder_model.bus_read(13'h0008, v);
    cmp_bit("acc carry low", 1'b1, v <= 16'h0001);
    cmp_bit("acc tenth done", 1'b1, done[6]);
    // tenth single timer: slot 7, number 10, preset 1
    i_ptc_ladder_model.set_slot(3'd7, 16'h0511, 16'h0001, 16'h0000);
    idle(100);
    cmp_bit("slow timer done", 1'b1, done[7]);
    i_ptc_ladder_model.bus_read(13'h000a, v);
    cmp_bit("slow timer step", 1'b1, v >= 16'h0001 && v <= 16'h0002);
    conclude();
  end
endmodule : tb_top
bind ptc_timer_counter_unit ptc_tcu_chk i_ptc_tcu_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .done(done), .preset_err(preset_err)
);
